//--- sfl_pkg.sv
package sfl_pkg;

  // Frame and sample shape
  localparam int SFL_OCTETS = 2;
  localparam int SFL_SAMPLE_W = 16;
  localparam int SFL_SYNC_MIN = 2;

  // Special and idle octets
  localparam logic [7:0] SFL_K28_1 = 8'h3C;
  localparam logic [7:0] SFL_K28_5 = 8'hBC;
  localparam logic [7:0] SFL_K28_7 = 8'hFC;
  localparam logic [7:0] SFL_D16_2 = 8'h50;
  localparam logic [7:0] SFL_D5_6 = 8'hC5;

  // Running disparity after reset: negative
  localparam logic SFL_RD_RESET = 1'b0;

  // Scrambler 1 + x^14 + x^15
  localparam int SFL_SCR_W = 15;
  localparam int SFL_TAP_A = 14;
  localparam int SFL_TAP_B = 15;
  localparam logic [14:0] SFL_SCR_RESET = 15'h0000;

  // 5b/6b codes for negative disparity, index is x
  localparam logic [31:0][5:0] SFL_TAB6 = {
    6'h2B, 6'h1E, 6'h2E, 6'h0E, 6'h36, 6'h16, 6'h26, 6'h33,
    6'h3A, 6'h1A, 6'h2A, 6'h0B, 6'h32, 6'h13, 6'h23, 6'h1B,
    6'h17, 6'h1C, 6'h2C, 6'h0D, 6'h34, 6'h15, 6'h25, 6'h39,
    6'h38, 6'h19, 6'h29, 6'h35, 6'h31, 6'h2D, 6'h1D, 6'h27};
  localparam logic [5:0] SFL_K28_6B = 6'h0F;
  localparam logic [5:0] SFL_D7_POS = 6'h07;

  // 3b/4b codes for negative disparity, index is y
  localparam logic [7:0][3:0] SFL_TAB4 = {
    4'hE, 4'h6, 4'hA, 4'hD, 4'hC, 4'h5, 4'h9, 4'hB};
  localparam logic [3:0] SFL_A7_4B = 4'h7;

  function automatic logic [2:0] sfl_ones(input logic [5:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < 6; i++)
    begin
      n = n + {2'b00, v[i]};
    end
    return n;
  endfunction

  // Returns {rd_out, abcdei, fghj}; bit 9 goes on the line first
  function automatic logic [10:0] sfl_enc(input logic [7:0] oct,
                                          input logic k,
                                          input logic rd);
    logic [5:0] s6;
    logic [3:0] s4;
    logic [4:0] x;
    logic [2:0] y;
    logic r1;
    logic bal4;
    logic alt;
    logic k28;
    x = oct[4:0];
    y = oct[7:5];
    k28 = k && (x == 5'h1C);
    s6 = k28 ? SFL_K28_6B : SFL_TAB6[x];
    // Sub-block 1 polarity choice
    if (rd && sfl_ones(s6) != 3'h3)
      s6 = ~s6;
    else if (rd && !k && x == 5'h07)
      s6 = SFL_D7_POS;
    r1 = (sfl_ones(s6) == 3'h3) ? rd : ~rd;
    // Alternate .7 avoids a run of five inside the code-group
    alt = (y == 3'h7) && (k || (!r1 && (x == 5'h11 || x == 5'h12 ||
          x == 5'h14)) || (r1 && (x == 5'h0B || x == 5'h0D ||
          x == 5'h0E)));
    s4 = alt ? SFL_A7_4B : SFL_TAB4[y];
    bal4 = (sfl_ones({2'b00, s4}) == 3'h2);
    if ((r1 && (!bal4 || y == 3'h3)) ||
        (k28 && rd && bal4 && y != 3'h3))
      s4 = ~s4;
    return {bal4 ? r1 : ~r1, s6, s4};
  endfunction

  // Self-synchronising scrambler, MSB first; returns {state, word}
  function automatic logic [30:0] sfl_scr(input logic [15:0] d,
                                          input logic [14:0] st,
                                          input logic descr);
    logic [15:0] o;
    logic [14:0] s;
    logic fb;
    s = st;
    o = 16'h0000;
    for (int i = 15; i >= 0; i--)
    begin
      fb = s[SFL_TAP_A - 1] ^ s[SFL_TAP_B - 1];
      o[i] = d[i] ^ fb;
      s = {s[13:0], descr ? d[i] : o[i]};
    end
    return {s, o};
  endfunction

endpackage

//--- sfl_link_if.sv
interface sfl_link_if;
  // Ten-bit code-group, bit 9 first on the line
  logic [9:0] code_group;
  // Sync request from the receiver, active low
  logic sync_req_n;
  modport tx (output code_group, input sync_req_n);
  modport rx (input code_group, output sync_req_n);
endinterface

//--- sfl_tx.sv
module sfl_tx
  import sfl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [15:0] sample_i,
  output logic sample_take_o,
  input wire logic scramble_en_i,
  input wire logic idle_sync_select_i,
  input wire logic frame_align_monitor_en_i,
  output logic syncing_o,
  sfl_link_if.tx link
);

  typedef enum logic [1:0] {
    TX_DATA = 2'b01,
    TX_SYNC = 2'b10
  } sfl_tx_state_e;

  sfl_tx_state_e state_q;
  sfl_tx_state_e frame_state;
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic scr_on;
  logic idle_on;
  logic fam_on;
  logic [1:0] lo_cnt_q;
  logic sync_hit;
  logic phase_q;
  logic rd_q;
  logic init_done_q;
  logic [14:0] scr_q;
  logic [30:0] scr_res;
  logic [15:0] word;
  logic [7:0] low_q;
  logic [7:0] prev_low_q;
  logic [7:0] oct;
  logic is_k;
  logic subst;
  logic [10:0] enc;
  logic [9:0] cg_q;

  // Mode pins come from outside; two flops before use
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
    end
    else if (ce_i)
    begin
      pin_s1_q <= {scramble_en_i, idle_sync_select_i,
                   frame_align_monitor_en_i};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign scr_on = pin_s2_q[2];
  assign idle_on = pin_s2_q[1];
  assign fam_on = pin_s2_q[0];

  // Request counts only after it has stayed low long enough
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      lo_cnt_q <= 2'h0;
    else if (ce_i)
    begin
      if (link.sync_req_n)
        lo_cnt_q <= 2'h0;
      else if (lo_cnt_q != 2'(SFL_SYNC_MIN))
        lo_cnt_q <= lo_cnt_q + 2'h1;
    end
  end

  assign sync_hit = (lo_cnt_q == 2'(SFL_SYNC_MIN));

  // Frame mode is decided only at the first octet, so a
  // release mid-frame never cuts a preamble frame short
  always_comb
  begin
    frame_state = state_q;
    if (!phase_q)
    begin
      unique case (state_q)
        TX_DATA:
        begin
          if (sync_hit)
            frame_state = TX_SYNC;
        end
        TX_SYNC:
        begin
          if (link.sync_req_n)
            frame_state = TX_DATA;
        end
      endcase
    end
  end

  assign scr_res = sfl_scr(sample_i, scr_q, 1'b0);
  assign word = scr_on ? scr_res[15:0] : sample_i;

  // Substitution needs both the enable and a finished sync
  // substitution condition
  assign subst = fam_on && init_done_q && (low_q == prev_low_q);

  // Octet selection for the current slot
  always_comb
  begin
    oct = 8'h00;
    is_k = 1'b0;
    unique case (frame_state)
      TX_SYNC:
      begin
        if (phase_q && idle_on)
          oct = rd_q ? SFL_D16_2 : SFL_D5_6;
        else
        begin
          oct = SFL_K28_5;
          is_k = 1'b1;
        end
      end
      TX_DATA:
      begin
        if (!phase_q)
          oct = word[15:8];
        else if (subst)
        begin
          oct = SFL_K28_7;
          is_k = 1'b1;
        end
        else
          oct = low_q;
      end
    endcase
  end

  assign enc = sfl_enc(oct, is_k, rd_q);

  // Line register and running disparity
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cg_q <= 10'h000;
      rd_q <= SFL_RD_RESET;
    end
    else if (ce_i)
    begin
      cg_q <= enc[9:0];
      rd_q <= enc[10];
    end
  end

  // Frame phase and mode
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      phase_q <= 1'b0;
      state_q <= TX_DATA;
    end
    else if (ce_i)
    begin
      phase_q <= ~phase_q;
      state_q <= frame_state;
    end
  end

  // Sync counts as done once a data frame follows a preamble
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      init_done_q <= 1'b0;
    else if (ce_i && !phase_q && state_q == TX_SYNC &&
             frame_state == TX_DATA)
      init_done_q <= 1'b1;
  end

  // Sample capture, low octet hold and scrambler state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      low_q <= 8'h00;
      prev_low_q <= 8'h00;
      scr_q <= SFL_SCR_RESET;
    end
    else if (ce_i && frame_state == TX_DATA)
    begin
      if (!phase_q)
      begin
        low_q <= word[7:0];
        if (scr_on)
          scr_q <= scr_res[30:16];
      end
      else
        prev_low_q <= low_q; // Original octet, not the marker
    end
  end

  // Sample is consumed on the first slot of a data frame
  assign sample_take_o = ce_i && !phase_q && frame_state == TX_DATA;
  assign syncing_o = (state_q == TX_SYNC);
  assign link.code_group = cg_q;

endmodule

//--- sfl_rx.sv
module sfl_rx
  import sfl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic sync_request_i,
  input wire logic descramble_en_i,
  input wire logic frame_align_monitor_en_i,
  output logic [15:0] sample_o,
  output logic sample_valid_o,
  output logic align_error_o,
  output logic synced_o,
  sfl_link_if.rx link
);

  typedef enum logic [2:0] {
    RX_HUNT = 3'b001,
    RX_WAIT = 3'b010,
    RX_DATA = 3'b100
  } sfl_rx_state_e;

  sfl_rx_state_e state_q;
  logic [1:0] hold_q;
  logic phase_q;
  logic [9:0] dec;
  logic hit;
  logic is_k;
  logic [7:0] oct;
  logic [7:0] hi_q;
  logic [7:0] prev_q;
  logic [7:0] low;
  logic [14:0] scr_q;
  logic [30:0] dsc;
  logic drop_q;
  logic comma5;

  // Brute-force decode against the encoder; slow but exact
  function automatic logic [9:0] sfl_dec(input logic [9:0] cg);
    logic [10:0] e;
    logic [9:0] r;
    r = 10'h000;
    for (int d = 0; d < 256; d++)
    begin
      for (int p = 0; p < 2; p++)
      begin
        e = sfl_enc(8'(d), 1'b0, p[0]);
        if (e[9:0] == cg)
          r = {2'b10, 8'(d)};
      end
    end
    for (int p = 0; p < 2; p++)
    begin
      e = sfl_enc(SFL_K28_5, 1'b1, p[0]);
      if (e[9:0] == cg)
        r = {2'b11, SFL_K28_5};
      e = sfl_enc(SFL_K28_7, 1'b1, p[0]);
      if (e[9:0] == cg)
        r = {2'b11, SFL_K28_7};
      e = sfl_enc(SFL_K28_1, 1'b1, p[0]);
      if (e[9:0] == cg)
        r = {2'b11, SFL_K28_1};
    end
    return r;
  endfunction

  assign dec = sfl_dec(link.code_group);
  assign hit = dec[9];
  assign is_k = dec[8];
  assign oct = dec[7:0];
  assign comma5 = hit && is_k && oct == SFL_K28_5;

  // restore the octet that the marker replaced
  assign low = (is_k && oct == SFL_K28_7 && frame_align_monitor_en_i)
               ? prev_q : oct;
  assign dsc = sfl_scr({hi_q, low}, scr_q, 1'b1);

  // Link state; request held low while hunting
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= RX_HUNT;
      hold_q <= 2'h0;
      phase_q <= 1'b0;
    end
    else if (ce_i)
    begin
      if (sync_request_i)
      begin
        state_q <= RX_HUNT;
        hold_q <= 2'h0;
      end
      else
      begin
        unique case (state_q)
          RX_HUNT:
          begin
            if (hold_q != 2'(SFL_SYNC_MIN))
              hold_q <= hold_q + 2'h1;
            else if (comma5)
            begin
              state_q <= RX_WAIT;
              phase_q <= 1'b1;
            end
          end
          RX_WAIT:
          begin
            if (comma5)
              phase_q <= ~phase_q;
            else if (phase_q)
              phase_q <= 1'b0; // Idle set filler octet
            else
            begin
              state_q <= RX_DATA;
              phase_q <= 1'b1;
            end
          end
          RX_DATA:
            phase_q <= ~phase_q;
        endcase
      end
    end
  end

  // Word assembly, marker check and descrambling
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hi_q <= 8'h00;
      prev_q <= 8'h00;
      scr_q <= SFL_SCR_RESET;
      drop_q <= 1'b1;
      sample_o <= 16'h0000;
      sample_valid_o <= 1'b0;
      align_error_o <= 1'b0;
    end
    else if (ce_i)
    begin
      sample_valid_o <= 1'b0;
      align_error_o <= 1'b0;
      if (state_q != RX_DATA)
        drop_q <= 1'b1;
      if ((state_q == RX_WAIT && !comma5 && !phase_q) ||
          (state_q == RX_DATA && !phase_q))
      begin
        hi_q <= oct;
        align_error_o <= !hit || is_k;
      end
      else if (state_q == RX_DATA)
      begin
        // A marker only belongs in the last slot
        align_error_o <= !hit || (is_k && low == oct);
        prev_q <= low;
        if (descramble_en_i)
          scr_q <= dsc[30:16];
        sample_o <= descramble_en_i ? dsc[15:0] : {hi_q, low};
        sample_valid_o <= !(drop_q && descramble_en_i);
        drop_q <= 1'b0;
      end
    end
  end

  assign link.sync_req_n = (state_q != RX_HUNT);
  assign synced_o = (state_q == RX_DATA);

endmodule

//--- sfl_link_monitor.sv
module sfl_link_monitor
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [9:0] code_group_i,
  input wire logic sync_req_n_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic live_q;
  logic slot0_q;
  logic rd_q;
  logic rd_mid;
  logic k285;
  logic [2:0] n6;
  logic [2:0] n4;

  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Weights of the two sub-blocks, bit 9 leads
  assign n6 = 3'($countones(code_group_i[9:4]));
  assign n4 = 3'($countones(code_group_i[3:0]));
  assign rd_mid = (n6 == 3'h3) ? rd_q : (n6 > 3'h3);
  assign k285 = code_group_i inside {10'h0FA, 10'h305};

  // Frame slot and disparity; the reset word is skipped, it is no code
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      live_q <= 1'b0;
      slot0_q <= 1'b0;
      rd_q <= 1'b0;
    end
    else
    begin
      live_q <= 1'b1;
      slot0_q <= ~slot0_q;
      if (live_q)
        rd_q <= (n4 == 3'h2) ? rd_mid : (n4 > 3'h2);
    end
  end

  property p_weight;
    live_q |-> n6 inside {[2:4]} && n4 inside {[1:3]};
  endproperty
  a_weight: assert property (p_weight)
    else $error("code-group weight out of range");
  property p_rd6;
    live_q && n6 != 3'h3 |-> (n6 > 3'h3) != rd_q;
  endproperty
  a_rd6: assert property (p_rd6)
    else $error("first sub-block breaks disparity");
  property p_rd4;
    live_q && n4 != 3'h2 |-> (n4 > 3'h2) != rd_mid;
  endproperty
  a_rd4: assert property (p_rd4)
    else $error("second sub-block breaks disparity");
  property p_comma;
    live_q && code_group_i[9:3] inside {7'h1F, 7'h60} |->
      code_group_i inside
      {10'h0F8, 10'h0F9, 10'h0FA, 10'h305, 10'h306, 10'h307};
  endproperty
  a_comma: assert property (p_comma)
    else $error("comma outside the three comma codes");
  property p_k287;
    live_q && code_group_i inside {10'h0F8, 10'h307} |-> !slot0_q;
  endproperty
  a_k287: assert property (p_k287)
    else $error("marker comma in first slot");
  property p_pre;
    live_q && k285 && !slot0_q |-> $past(k285);
  endproperty
  a_pre: assert property (p_pre)
    else $error("preamble frame not started in first slot");
  property p_idle;
    live_q && !slot0_q && $past(code_group_i) == 10'h0FA |->
      code_group_i inside {10'h305, 10'h245};
  endproperty
  a_idle: assert property (p_idle)
    else $error("bad code after positive-ending comma");
  property p_idle_neg;
    live_q && !slot0_q && $past(code_group_i) == 10'h305 |->
      code_group_i inside {10'h0FA, 10'h296};
  endproperty
  a_idle_neg: assert property (p_idle_neg)
    else $error("bad code after negative-ending comma");
  property p_answer;
    (!sync_req_n_i) [*2] |-> ##[0:6] k285;
  endproperty
  a_answer: assert property (p_answer)
    else $error("sync request not answered by commas");
  property p_release;
    $rose(sync_req_n_i) |-> $past(k285) || $past(k285, 2);
  endproperty
  a_release: assert property (p_release)
    else $error("request dropped without a comma");
  // A one-cycle request would be ignored by the sender
  property p_req_hold;
    $fell(sync_req_n_i) |=> !sync_req_n_i;
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("sync request shorter than two cycles");

  c_marker: cover property (code_group_i inside {10'h0F8, 10'h307});
  c_idle: cover property (code_group_i inside {10'h245, 10'h296});
  c_release: cover property ($rose(sync_req_n_i));
endmodule

//--- serial_adc_frame_link_tx_bench.sv
module serial_adc_frame_link_tx_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [15:0] sample_i = 16'h0000;
  logic scr = 1'b0;
  logic idl = 1'b0;
  logic frame_align_monitor_en = 1'b0;
  logic req = 1'b0;
  logic take, syncing, valid, aerr, synced;
  logic [15:0] rx_word;
  logic [7:0] cnt = 8'h00;
  logic en = 1'b0;
  logic armed = 1'b0;
  logic adv = 1'b0;
  logic hi_chk = 1'b0;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;
  int got = 0;
  int k7 = 0;
  int drop_n = 0;
  logic [15:0] sent_q [$];
  logic [2:0] modes [4] = '{3'b000, 3'b010, 3'b001, 3'b110};

  sfl_link_if sfl_link_if_inst ();
  sfl_tx sfl_tx_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .sample_i(sample_i), .sample_take_o(take), .scramble_en_i(scr),
    .idle_sync_select_i(idl), .frame_align_monitor_en_i(frame_align_monitor_en),
    .syncing_o(syncing), .link(sfl_link_if_inst));
  sfl_rx sfl_rx_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .sync_request_i(req), .descramble_en_i(scr),
    .frame_align_monitor_en_i(frame_align_monitor_en), .sample_o(rx_word),
    .sample_valid_o(valid), .align_error_o(aerr), .synced_o(synced),
    .link(sfl_link_if_inst));
  sfl_link_monitor sfl_link_monitor_inst (.clk_i(clk_i), .rst_i(rst_i),
    .code_group_i(sfl_link_if_inst.code_group),
    .sync_req_n_i(sfl_link_if_inst.sync_req_n));

  initial
  begin
    forever #50 clk_i = ~clk_i;
  end

  task automatic check(input logic [15:0] act, input logic [15:0] exp);
    checks++;
    if (act !== exp)
    begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, act, exp);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic step();
    @(posedge clk_i);
    #1;
  endtask

  // Hang guard, well above four tests of some 75 cycles
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_count++;
      conclude();
    end
  end

  // New sample after each take; a fixed low octet triggers the marker
  always @(posedge clk_i)
  begin
    #1;
    if (adv)
    begin
      cnt = cnt + 8'h01;
      sample_i = {cnt[0] ? 8'hBC : cnt, frame_align_monitor_en ? 8'h5A : ~cnt};
    end
  end

  // Mid-cycle sampling, after the edge's updates have landed
  always @(negedge clk_i)
  begin
    // D28.5 has one form for either disparity
    if (hi_chk)
      check(16'(sfl_link_if_inst.code_group), 16'h00EA);
    hi_chk = armed && take && !scr && sample_i[15:8] == 8'hBC;
    if (en && syncing)
    begin
      armed = 1'b1;
      sent_q.delete();
      drop_n = int'(scr);
    end
    if (armed && take)
      sent_q.push_back(sample_i);
    adv = take;
    if (armed && sfl_link_if_inst.code_group inside {10'h0F8, 10'h307})
      k7++;
    if (armed)
      check(16'(aerr), 16'h0000);
    if (armed && valid)
    begin
      got++;
      // The receiver withholds its first descrambled word, so the
      // sample behind it never shows up as valid
      if (drop_n > 0 && sent_q.size() > 0)
      begin
        drop_n--;
        sent_q.delete(0);
      end
      if (sent_q.size() > 0)
        check(rx_word, sent_q.pop_front());
      else
        check(16'h0001, 16'h0000);
    end
  end

  // Modes settle before the request; the tx mode pins lag two cycles
  task automatic run_test(input logic [2:0] m);
    int n;
    en = 1'b0;
    armed = 1'b0;
    {scr, idl, frame_align_monitor_en} = m;
    repeat (4) step();
    req = 1'b1;
    step();
    req = 1'b0;
    en = 1'b1;
    got = 0;
    k7 = 0;
    n = 0;
    while (!(armed && synced === 1'b1) && n < 80)
    begin
      step();
      n++;
    end
    check(16'(armed && synced === 1'b1), 16'h0001);
    repeat (60) step();
    check(16'(got >= 20), 16'h0001);
    check(16'(k7 > 0), 16'(frame_align_monitor_en));
    $display("Test mode %b done, %0d words", m, got);
  endtask

  initial
  begin
    repeat (4) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    foreach (modes[i])
      run_test(modes[i]);
    conclude();
  end
endmodule
